// ==== core/hps_pkg.sv ====
// shared constants, config layout and state codes of the host port block
package hps_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TP_PERIOD_S   = 1;
  localparam int unsigned TP_PERIOD_CYC = CLK_HZ * TP_PERIOD_S;
  localparam int unsigned TP_WIDTH_MS   = 100;
  localparam int unsigned TP_WIDTH_CYC  = (CLK_HZ / 1000) * TP_WIDTH_MS;
  localparam int unsigned CNT_W         = 9;
  // synced pin vector positions
  localparam int unsigned PIN_RSTN      = 5;
  localparam int unsigned PIN_DSEL      = 4;
  localparam int unsigned PIN_RXD       = 3;
  localparam int unsigned PIN_SCL       = 2;
  localparam int unsigned PIN_SDA       = 1;
  localparam int unsigned PIN_EXT       = 0;
  localparam logic [5:0]  PIN_IDLE      = 6'h3f;
  localparam logic        SEL_UART_TWO_WIRE = 1'h1;
  localparam logic [7:0]  IDLE_BYTE     = 8'hff;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [15:0] BAUD_DIV_RST  = 16'h06c8;
  localparam logic [6:0]  I2C_ADDR_RST  = 7'h42;
  localparam logic [8:0]  THRESH_RST    = 9'h001;

  typedef struct packed {
    logic [31:0]      tp_period;
    logic [15:0]      baud_div;
    logic [CNT_W-1:0] txrdy_thresh;
    logic [6:0]       i2c_addr;
    logic             txrdy_en;
    logic             txrdy_pol;
    logic             txrdy_on_txd;
  } hps_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } hps_byte_t;

  localparam hps_cfg_t CFG_RST = '{tp_period: 32'h0, baud_div: BAUD_DIV_RST,
                                   txrdy_thresh: THRESH_RST, i2c_addr: I2C_ADDR_RST,
                                   txrdy_en: 1'h0, txrdy_pol: 1'h1, txrdy_on_txd: 1'h0};

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDR  = 3'b001,
    I2C_ACK   = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_READ  = 3'b100,
    I2C_MACK  = 3'b101
  } hps_i2c_st_t;

  typedef enum logic [1:0] {
    U_IDLE  = 2'b00,
    U_START = 2'b01,
    U_DATA  = 2'b10,
    U_STOP  = 2'b11
  } hps_uart_st_t;
endpackage : hps_pkg

// ==== core/hps_sync.sv ====
// two-flop synchroniser with edge detection for a vector of pins
`timescale 1ns/1ps
module hps_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  // stages one and two run through reset, so a strap is seen while reset is held
  always_ff @(posedge clk) begin
    s1_q <= d;
    s2_q <= s1_q;
  end

  // edge stage starts from the idle levels; only stage two feeds it
  always_ff @(posedge clk) begin
    if (rst) begin
      s3_q <= INIT;
    end else begin
      s3_q <= s2_q;
    end
  end

  assign q    = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule : hps_sync

// ==== core/hps_uart.sv ====
// asynchronous serial transmitter and receiver, 8n1, divisor-set baud rate
`timescale 1ns/1ps
module hps_uart
  import hps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] baud_div,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             txd,
  input  wire logic        rxd,
  output logic [7:0]       rx_data,
  output logic             rx_valid
);
  hps_uart_st_t t_st_q, t_st_d, r_st_q, r_st_d;
  logic [15:0]  t_cnt_q, t_cnt_d, r_cnt_q, r_cnt_d, div;
  logic [3:0]   t_bit_q, t_bit_d, r_bit_q, r_bit_d;
  logic [7:0]   t_sh_q, t_sh_d, r_sh_q, r_sh_d;
  logic         txd_q, txd_d, rv_q, rv_d;

  // a zero divisor would stall the bit timer, so it counts as one
  assign div = (baud_div == 16'h0000) ? 16'h0001 : baud_div;

  // transmit: no handshake lines, a byte goes as soon as it is offered
  always_comb begin
    t_st_d  = t_st_q;
    t_cnt_d = t_cnt_q;
    t_bit_d = t_bit_q;
    t_sh_d  = t_sh_q;
    txd_d   = txd_q;
    if (t_st_q == U_IDLE) begin
      txd_d = 1'b1;
      if (tx_valid) begin
        t_sh_d  = tx_data;
        t_cnt_d = div;
        t_st_d  = U_START;
        txd_d   = 1'b0;
      end
    end else if (t_cnt_q > 16'h0001) begin
      t_cnt_d = t_cnt_q - 16'h0001;
    end else begin
      t_cnt_d = div;
      case (t_st_q)
        U_START: begin
          t_st_d  = U_DATA;
          t_bit_d = 4'h0;
          txd_d   = t_sh_q[0];
          t_sh_d  = {1'b0, t_sh_q[7:1]};
        end
        U_DATA: begin
          if (t_bit_q == BIT_LAST) begin
            t_st_d = U_STOP;
            txd_d  = 1'b1;
          end else begin
            t_bit_d = t_bit_q + 4'h1;
            txd_d   = t_sh_q[0];
            t_sh_d  = {1'b0, t_sh_q[7:1]};
          end
        end
        default: t_st_d = U_IDLE;
      endcase
    end
  end

  // receive: sample mid-bit, drop bytes with a bad stop bit
  always_comb begin
    r_st_d  = r_st_q;
    r_cnt_d = r_cnt_q;
    r_bit_d = r_bit_q;
    r_sh_d  = r_sh_q;
    rv_d    = 1'b0;
    if (r_st_q == U_IDLE) begin
      if (!rxd) begin
        r_st_d  = U_START;
        r_cnt_d = {1'b0, div[15:1]} + 16'h0001;
      end
    end else if (r_cnt_q > 16'h0001) begin
      r_cnt_d = r_cnt_q - 16'h0001;
    end else begin
      r_cnt_d = div;
      case (r_st_q)
        U_START: begin
          r_st_d  = rxd ? U_IDLE : U_DATA;  // glitch, not a start bit
          r_bit_d = 4'h0;
        end
        U_DATA: begin
          r_sh_d  = {rxd, r_sh_q[7:1]};
          r_bit_d = r_bit_q + 4'h1;
          if (r_bit_q == BIT_LAST) r_st_d = U_STOP;
        end
        default: begin
          rv_d   = rxd;
          r_st_d = U_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_st_q  <= U_IDLE;
      t_cnt_q <= 16'h0000;
      t_bit_q <= 4'h0;
      t_sh_q  <= 8'h00;
      txd_q   <= 1'b1;
      r_st_q  <= U_IDLE;
      r_cnt_q <= 16'h0000;
      r_bit_q <= 4'h0;
      r_sh_q  <= 8'h00;
      rv_q    <= 1'b0;
    end else begin
      t_st_q  <= t_st_d;
      t_cnt_q <= t_cnt_d;
      t_bit_q <= t_bit_d;
      t_sh_q  <= t_sh_d;
      txd_q   <= txd_d;
      r_st_q  <= r_st_d;
      r_cnt_q <= r_cnt_d;
      r_bit_q <= r_bit_d;
      r_sh_q  <= r_sh_d;
      rv_q    <= rv_d;
    end
  end

  assign tx_ready = (t_st_q == U_IDLE);
  assign txd      = txd_q;
  assign rx_data  = r_sh_q;
  assign rx_valid = rv_q;
endmodule : hps_uart

// ==== core/hps_top.sv ====
// host port select, two-wire slave, spi slave, data-pending, time pulse
`timescale 1ns/1ps
module hps_top
  import hps_pkg::*;
#(
  parameter int unsigned TP_PERIOD = TP_PERIOD_CYC,
  parameter int unsigned TP_WIDTH  = TP_WIDTH_CYC
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RESET,
  input  wire logic             CFG_WE,
  input  wire hps_cfg_t         CFG,
  input  wire logic [7:0]       OUT_DATA,
  input  wire logic             OUT_VALID,
  output logic                  OUT_READY,
  input  wire logic [CNT_W-1:0] OUT_COUNT,
  output hps_byte_t             IN_BYTE,
  input  wire logic             POWER_SAVE,
  input  wire logic             RESET_N,
  input  wire logic             D_SEL,
  input  wire logic             RXD_MOSI,
  input  wire logic             SCL_SCK,
  input  wire logic             SDA_CSN_I,
  output logic                  SDA_CSN_O,
  output logic                  SDA_CSN_OE,
  output logic                  TXD_MISO_O,
  output logic                  TXD_MISO_OE,
  input  wire logic             WAKE_EVENT_INPUT,
  output logic                  TIMEPULSE,
  output logic                  ANTENNA_POWER_CTRL,
  output logic                  SYS_RESET,
  output logic                  WAKE_REQ,
  output logic                  AID_EVENT
);
  logic [5:0]  pin_s, pin_rise, pin_fall;
  logic        rst, uart_mode, avail, pending, txrdy_lvl;
  logic        scl_s, sda_s, start, stop, i2c_load, spi_load;
  logic        u_tx_valid, u_tx_ready, u_txd, u_rx_valid, uart_pop;
  logic [7:0]  u_rx_data, byte_out;
  hps_cfg_t    cfg_q, cfg_d;
  logic        sel_q, sel_d;
  logic        pop_q, pop_d, txd_q, txd_d, oe_q, oe_d;
  logic        ant_q, ant_d, wake_q, wake_d, aid_q, aid_d, srst_q, srst_d;
  hps_byte_t   in_q, in_d;
  logic [31:0] tp_cnt_q, tp_cnt_d;
  logic        tp_q, tp_d;
  hps_i2c_st_t i2_st_q, i2_st_d;
  logic [3:0]  i2_cnt_q, i2_cnt_d, sp_cnt_q, sp_cnt_d;
  logic [7:0]  i2_sh_q, i2_sh_d, sp_rx_q, sp_rx_d, sp_tx_q, sp_tx_d;
  logic        i2_rw_q, i2_rw_d, i2_low_q, i2_low_d, i2_ack_q, i2_ack_d, i2_in_v;
  logic        sp_miso_q, sp_miso_d, sp_oe_q, sp_oe_d, sp_in_v;

  // every pin crosses two flops; idle levels match the internal pull-ups
  hps_sync #(.W(6), .INIT(PIN_IDLE)) u_pin_sync (
    .clk  (SYS_CLK),
    .rst  (RESET),
    .d    ({RESET_N, D_SEL, RXD_MOSI, SCL_SCK, SDA_CSN_I, WAKE_EVENT_INPUT}),
    .q    (pin_s),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  assign rst       = RESET | ~pin_s[PIN_RSTN];
  assign uart_mode = (sel_q == SEL_UART_TWO_WIRE);
  assign scl_s     = pin_s[PIN_SCL];
  assign sda_s     = pin_s[PIN_SDA];
  assign start     = pin_fall[PIN_SDA] & scl_s;
  assign stop      = pin_rise[PIN_SDA] & scl_s;
  assign avail     = OUT_VALID & ~pop_q;
  assign byte_out  = avail ? OUT_DATA : IDLE_BYTE;

  // two-wire reads win over the serial transmitter for the same byte
  assign u_tx_valid = uart_mode & ~cfg_q.txrdy_on_txd & avail & ~i2c_load;
  assign uart_pop   = u_tx_valid & u_tx_ready;

  hps_uart u_uart (
    .clk      (SYS_CLK),
    .rst      (rst),
    .baud_div (cfg_q.baud_div),
    .tx_data  (OUT_DATA),
    .tx_valid (u_tx_valid),
    .tx_ready (u_tx_ready),
    .txd      (u_txd),
    .rxd      (pin_s[PIN_RXD]),
    .rx_data  (u_rx_data),
    .rx_valid (u_rx_valid)
  );

  // strap is caught while reset is held and frozen after release
  assign sel_d = rst ? pin_s[PIN_DSEL] : sel_q;

  always_ff @(posedge SYS_CLK) begin
    sel_q <= sel_d;
  end

  // data-pending level: count at or above threshold, never for an empty buffer
  assign pending   = cfg_q.txrdy_en & (OUT_COUNT != '0)
                   & (OUT_COUNT >= cfg_q.txrdy_thresh);
  assign txrdy_lvl = cfg_q.txrdy_pol ? pending : ~pending;

  // config, pin drive, byte hand-off and side-band outputs
  always_comb begin
    cfg_d  = CFG_WE ? CFG : cfg_q;
    pop_d  = avail & (i2c_load | spi_load | uart_pop);
    ant_d  = ~POWER_SAVE;
    wake_d = pin_fall[PIN_EXT] & POWER_SAVE;
    aid_d  = pin_fall[PIN_EXT] & ~POWER_SAVE;
    srst_d = ~pin_s[PIN_RSTN];
    if (!uart_mode) begin
      txd_d = sp_miso_q;
      oe_d  = sp_oe_q;
    end else if (cfg_q.txrdy_en && cfg_q.txrdy_on_txd) begin
      txd_d = txrdy_lvl;
      oe_d  = 1'b1;
    end else begin
      txd_d = u_txd;
      oe_d  = 1'b1;
    end
    // two-wire write has priority; a coincident serial byte is dropped
    if (i2_in_v) begin
      in_d = '{data: i2_sh_q, valid: 1'b1};
    end else if (sp_in_v) begin
      in_d = '{data: sp_rx_d, valid: 1'b1};
    end else begin
      in_d = '{data: u_rx_data, valid: uart_mode & u_rx_valid};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      cfg_q           <= CFG_RST;
      cfg_q.tp_period <= TP_PERIOD;
      pop_q           <= 1'b0;
      txd_q           <= 1'b1;
      oe_q            <= 1'b0;
      ant_q           <= 1'b0;
      wake_q          <= 1'b0;
      aid_q           <= 1'b0;
      in_q            <= '0;
    end else begin
      cfg_q  <= cfg_d;
      pop_q  <= pop_d;
      txd_q  <= txd_d;
      oe_q   <= oe_d;
      ant_q  <= ant_d;
      wake_q <= wake_d;
      aid_q  <= aid_d;
      in_q   <= in_d;
    end
  end

  // reset indicator must run through the pin reset it reports
  always_ff @(posedge SYS_CLK) begin
    if (RESET) srst_q <= 1'b0;
    else       srst_q <= srst_d;
  end

  // time pulse: period from config, fixed high width, zero period stops it
  always_comb begin
    if (tp_cnt_q + 32'h1 >= cfg_q.tp_period) tp_cnt_d = 32'h0;
    else                                     tp_cnt_d = tp_cnt_q + 32'h1;
    tp_d = (cfg_q.tp_period != 32'h0) && (tp_cnt_q < TP_WIDTH);
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      tp_cnt_q <= 32'h0;
      tp_q     <= 1'b0;
    end else begin
      tp_cnt_q <= tp_cnt_d;
      tp_q     <= tp_d;
    end
  end

  // two-wire slave: shift on clock rise, change data only on clock fall
  always_comb begin
    i2_st_d  = i2_st_q;
    i2_cnt_d = i2_cnt_q;
    i2_sh_d  = i2_sh_q;
    i2_rw_d  = i2_rw_q;
    i2_low_d = i2_low_q;
    i2_ack_d = i2_ack_q;
    i2c_load = 1'b0;
    i2_in_v  = 1'b0;
    if (!uart_mode || stop) begin
      i2_st_d  = I2C_IDLE;
      i2_low_d = 1'b0;
    end else if (start) begin
      i2_st_d  = I2C_ADDR;
      i2_cnt_d = 4'h0;
      i2_low_d = 1'b0;
    end else if (pin_rise[PIN_SCL]) begin
      case (i2_st_q)
        I2C_ADDR, I2C_WRITE: begin
          i2_sh_d  = {i2_sh_q[6:0], sda_s};
          i2_cnt_d = i2_cnt_q + 4'h1;
        end
        I2C_MACK: i2_ack_d = ~sda_s;
        default: ;
      endcase
    end else if (pin_fall[PIN_SCL]) begin
      case (i2_st_q)
        I2C_ADDR: begin
          if (i2_cnt_q == BYTE_BITS) begin
            if (i2_sh_q[7:1] == cfg_q.i2c_addr) begin
              i2_st_d  = I2C_ACK;
              i2_low_d = 1'b1;
              i2_rw_d  = i2_sh_q[0];
            end else begin
              i2_st_d = I2C_IDLE;
            end
          end
        end
        I2C_WRITE: begin
          if (i2_cnt_q == BYTE_BITS) begin
            i2_st_d  = I2C_ACK;
            i2_low_d = 1'b1;
            i2_in_v  = 1'b1;
          end
        end
        I2C_ACK, I2C_MACK: begin
          if (i2_st_q == I2C_ACK && !i2_rw_q) begin
            i2_st_d  = I2C_WRITE;
            i2_cnt_d = 4'h0;
            i2_low_d = 1'b0;
          end else if (i2_st_q == I2C_ACK || i2_ack_q) begin
            i2_st_d  = I2C_READ;  // empty buffer reads as idle bytes
            i2_cnt_d = 4'h0;
            i2_sh_d  = byte_out;
            i2_low_d = ~byte_out[7];
            i2c_load = 1'b1;
          end else begin
            i2_st_d  = I2C_IDLE;  // master nack ends the read
            i2_low_d = 1'b0;
          end
        end
        I2C_READ: begin
          if (i2_cnt_q == BIT_LAST) begin
            i2_st_d  = I2C_MACK;
            i2_low_d = 1'b0;
          end else begin
            i2_cnt_d = i2_cnt_q + 4'h1;
            i2_sh_d  = {i2_sh_q[6:0], 1'b0};
            i2_low_d = ~i2_sh_q[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      i2_st_q  <= I2C_IDLE;
      i2_cnt_q <= 4'h0;
      i2_sh_q  <= 8'h00;
      i2_rw_q  <= 1'b0;
      i2_low_q <= 1'b0;
      i2_ack_q <= 1'b0;
    end else begin
      i2_st_q  <= i2_st_d;
      i2_cnt_q <= i2_cnt_d;
      i2_sh_q  <= i2_sh_d;
      i2_rw_q  <= i2_rw_d;
      i2_low_q <= i2_low_d;
      i2_ack_q <= i2_ack_d;
    end
  end

  // spi slave mode 0: sample mosi on clock rise, shift miso on fall
  always_comb begin
    sp_cnt_d  = sp_cnt_q;
    sp_rx_d   = sp_rx_q;
    sp_tx_d   = sp_tx_q;
    sp_miso_d = sp_miso_q;
    sp_oe_d   = sp_oe_q;
    spi_load  = 1'b0;
    sp_in_v   = 1'b0;
    if (uart_mode || sda_s) begin
      sp_cnt_d = 4'h0;
      sp_oe_d  = 1'b0;
    end else if (pin_fall[PIN_SDA]) begin
      sp_tx_d   = byte_out;
      sp_miso_d = byte_out[7];
      sp_oe_d   = 1'b1;
      sp_cnt_d  = 4'h0;
      spi_load  = 1'b1;
    end else if (pin_rise[PIN_SCL]) begin
      sp_rx_d = {sp_rx_q[6:0], pin_s[PIN_RXD]};
      if (sp_cnt_q == BIT_LAST) begin
        sp_cnt_d = 4'h0;
        sp_in_v  = 1'b1;
      end else begin
        sp_cnt_d = sp_cnt_q + 4'h1;
      end
    end else if (pin_fall[PIN_SCL]) begin
      if (sp_cnt_q == 4'h0) begin
        sp_tx_d   = byte_out;
        sp_miso_d = byte_out[7];
        spi_load  = 1'b1;
      end else begin
        sp_tx_d   = {sp_tx_q[6:0], 1'b0};
        sp_miso_d = sp_tx_q[6];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      sp_cnt_q  <= 4'h0;
      sp_rx_q   <= 8'h00;
      sp_tx_q   <= 8'h00;
      sp_miso_q <= 1'b1;
      sp_oe_q   <= 1'b0;
    end else begin
      sp_cnt_q  <= sp_cnt_d;
      sp_rx_q   <= sp_rx_d;
      sp_tx_q   <= sp_tx_d;
      sp_miso_q <= sp_miso_d;
      sp_oe_q   <= sp_oe_d;
    end
  end

  // open drain data line: only ever pulled low, never driven high
  assign SDA_CSN_O   = 1'b0;
  assign SDA_CSN_OE  = i2_low_q;
  assign OUT_READY   = pop_q;
  assign IN_BYTE     = in_q;
  assign TXD_MISO_O  = txd_q;
  assign TXD_MISO_OE = oe_q;
  assign TIMEPULSE   = tp_q;
  assign ANTENNA_POWER_CTRL = ant_q;
  assign SYS_RESET   = srst_q;
  assign WAKE_REQ    = wake_q;
  assign AID_EVENT   = aid_q;
endmodule : hps_top

// ==== tb/hps_top_assertions.sv ====
// pin-level checks of the host port block
`timescale 1ns/1ps
module hps_top_assertions
  import hps_pkg::*;
#(
  parameter int unsigned TP_PERIOD = TP_PERIOD_CYC,
  parameter int unsigned TP_WIDTH  = TP_WIDTH_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic OUT_READY,
  input wire logic POWER_SAVE,
  input wire logic RESET_N,
  input wire logic D_SEL,
  input wire logic SDA_CSN_I,
  input wire logic SDA_CSN_O,
  input wire logic SDA_CSN_OE,
  input wire logic TXD_MISO_OE,
  input wire logic WAKE_EVENT_INPUT,
  input wire logic TIMEPULSE,
  input wire logic ANTENNA_POWER_CTRL,
  input wire logic SYS_RESET,
  input wire logic WAKE_REQ,
  input wire logic AID_EVENT
);
  logic [31:0] hi_cnt_q;
  logic [31:0] hi_cnt_d;

  // length of the running time pulse; cleared while low
  always_comb begin
    hi_cnt_d = TIMEPULSE ? hi_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge SYS_CLK) begin
    hi_cnt_q <= RESET ? 32'h0 : hi_cnt_d;
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  ant_off_a: assert property (POWER_SAVE |=> !ANTENNA_POWER_CTRL)
    else $error("antenna control on in power save");
  sys_rst_hold_a: assert property (!RESET_N [*6] |-> SYS_RESET)
    else $error("reset pin low but no system reset");
  sys_rst_rel_a: assert property (RESET_N [*6] |-> !SYS_RESET)
    else $error("system reset with reset pin high");
  wake_evt_a: assert property ($fell(WAKE_EVENT_INPUT) && POWER_SAVE |=>
    POWER_SAVE throughout (##[1:5] WAKE_REQ)) else $error("no wake request");
  aid_evt_a: assert property ($fell(WAKE_EVENT_INPUT) && !POWER_SAVE |-> ##[2:6] AID_EVENT)
    else $error("no aiding event");
  uart_oe_a: assert property ((D_SEL && RESET_N) [*8] |-> TXD_MISO_OE)
    else $error("serial transmit not driven");
  miso_off_a: assert property ((!D_SEL && RESET_N && SDA_CSN_I) [*6] |-> !TXD_MISO_OE)
    else $error("miso driven while deselected");
  spi_sda_a: assert property ((!D_SEL && RESET_N) [*6] |-> !SDA_CSN_OE)
    else $error("chip select pin driven in spi mode");
  sda_od_a: assert property (SDA_CSN_OE |-> SDA_CSN_O == 1'h0)
    else $error("data line driven high");
  tp_width_a: assert property ($fell(TIMEPULSE) && RESET_N |-> hi_cnt_q == TP_WIDTH)
    else $error("time pulse width wrong");
  ready_gap_a: assert property (OUT_READY |=> !OUT_READY)
    else $error("byte taken on two cycles in a row");
endmodule : hps_top_assertions

bind hps_top hps_top_assertions #(.TP_PERIOD(TP_PERIOD), .TP_WIDTH(TP_WIDTH))
  i_hps_top_assertions (.SYS_CLK(SYS_CLK), .RESET(RESET), .OUT_READY(OUT_READY),
  .POWER_SAVE(POWER_SAVE), .RESET_N(RESET_N), .D_SEL(D_SEL), .SDA_CSN_I(SDA_CSN_I),
  .SDA_CSN_O(SDA_CSN_O), .SDA_CSN_OE(SDA_CSN_OE), .TXD_MISO_OE(TXD_MISO_OE),
  .WAKE_EVENT_INPUT(WAKE_EVENT_INPUT), .TIMEPULSE(TIMEPULSE),
  .ANTENNA_POWER_CTRL(ANTENNA_POWER_CTRL), .SYS_RESET(SYS_RESET),
  .WAKE_REQ(WAKE_REQ), .AID_EVENT(AID_EVENT));

// ==== tb/hps_host_model.sv ====
// host processor model on the two-wire, spi and serial pins
`timescale 1ns/1ps
module hps_host_model (
  output logic     scl,
  output logic     sda_low,
  output logic     rxd,
  input wire logic sda,
  input wire logic miso
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
    rxd = 1'h1;
  end

  // one 125 ns bit slot; the host alone makes the clock
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #31 scl = 1'h1;
    #31 r = sda;
    #32 scl = 1'h0;
    #31;
  endtask : bit_io

  // start and stop: data moves while the clock is high
  task automatic i2c_start();
    sda_low = 1'h0;
    scl = 1'h1;
    #62 sda_low = 1'h1;
    #62 scl = 1'h0;
    #31;
  endtask : i2c_start
  task automatic i2c_stop();
    sda_low = 1'h1;
    #31 scl = 1'h1;
    #62 sda_low = 1'h0;
    #62;
  endtask : i2c_stop

  // eight bits msb first, then the acknowledge slot released
  task automatic i2c_xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'h1, ack);
  endtask : i2c_xfer

  // 8n1 frame, no handshake line to wait on
  task automatic uart_send(input logic [7:0] b, input int bit_ns);
    rxd = 1'h0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #(bit_ns);
    end
    rxd = 1'h1;
    #(bit_ns);
  endtask : uart_send

  // 8n1 frame out of the transmit pin, each bit taken at its middle
  task automatic uart_recv(output logic [7:0] r, input int bit_ns);
    wait (miso === 1'h0);
    #(bit_ns / 2);
    for (int i = 0; i < 8; i++) begin
      #(bit_ns);
      r[i] = miso;
    end
    #(bit_ns);
  endtask : uart_recv

  // mode 0 frame; mosi is garbage once the frame is over
  task automatic spi_xfer(input logic [7:0] b, output logic [7:0] r);
    scl = 1'h0;
    #125 sda_low = 1'h1;
    #125;
    for (int i = 7; i >= 0; i--) begin
      rxd = b[i];
      #62 scl = 1'h1;
      r[i] = miso;
      #63 scl = 1'h0;
    end
    #125 sda_low = 1'h0;
    rxd = !rxd;
  endtask : spi_xfer
endmodule : hps_host_model

// ==== tb/hps_top_bench.sv ====
// self-checking bench of the host port block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module hps_top_bench;
  import hps_pkg::*;
  localparam int unsigned TP_P = 200;
  localparam int unsigned TP_W = 20;
  logic             clk = 1'h0, rst = 1'h1, cfg_we = 1'h0, d_sel = 1'h1;
  hps_cfg_t         cfg = CFG_RST;
  logic [7:0]       out_data = 8'h00, b, r, exp_b;
  logic             out_valid = 1'h0, power_save = 1'h0, pin_low = 1'h0, wake_in = 1'h1;
  logic [CNT_W-1:0] out_count = '0, thr;
  logic             ack, hit;
  logic [7:0]       exp_q[$];
  int               err_count = 0, tests_run = 0, seed = 88, n, wake_n = 0, aid_n = 0;
  hps_byte_t        in_byte;
  logic             out_ready, sda_o, sda_oe, txd, txd_oe, tp, ant, sys_rst, wake, aid;
  logic             scl, sda_low, rxd;
  tri1              rst_n;
  wire              sda = (sda_low || (sda_oe && !sda_o)) ? 1'h0 : 1'h1;
  wire              miso = txd_oe ? txd : 1'hz;

  // reset pin is only ever pulled low or left to its pull-up
  assign rst_n = pin_low ? 1'h0 : 1'hz;
  always #2.5 clk = ~clk;

  hps_top #(.TP_PERIOD(TP_P), .TP_WIDTH(TP_W)) i_hps_top (
    .SYS_CLK(clk), .RESET(rst), .CFG_WE(cfg_we), .CFG(cfg), .OUT_DATA(out_data),
    .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_COUNT(out_count), .IN_BYTE(in_byte),
    .POWER_SAVE(power_save), .RESET_N(rst_n), .D_SEL(d_sel), .RXD_MOSI(rxd), .SCL_SCK(scl),
    .SDA_CSN_I(sda), .SDA_CSN_O(sda_o), .SDA_CSN_OE(sda_oe), .TXD_MISO_O(txd),
    .TXD_MISO_OE(txd_oe), .WAKE_EVENT_INPUT(wake_in), .TIMEPULSE(tp),
    .ANTENNA_POWER_CTRL(ant), .SYS_RESET(sys_rst), .WAKE_REQ(wake), .AID_EVENT(aid));
  hps_host_model i_hps_host_model (.scl(scl), .sda_low(sda_low), .rxd(rxd), .sda(sda),
    .miso(miso));

  // every host byte must be the next one the model queued
  always @(posedge clk) begin
    wake_n += (wake === 1'h1);
    aid_n += (aid === 1'h1);
    if (in_byte.valid === 1'h1) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `CHK(in_byte.data, exp_b)
    end
  end
  // the byte source moves on once its byte is taken
  always @(posedge clk) if (out_ready === 1'h1) begin
    #1 out_valid = 1'h0;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset(input logic sel);
    rst = 1'h1;
    d_sel = sel;
    tick(20);
    rst = 1'h0;
    tick(2);
  endtask : do_reset
  task automatic set_cfg(input logic en, pol, on, input logic [CNT_W-1:0] th);
    cfg = '{tp_period: TP_P, baud_div: 16'h0010, txrdy_thresh: th, i2c_addr: I2C_ADDR_RST,
            txrdy_en: en, txrdy_pol: pol, txrdy_on_txd: on};
    cfg_we = 1'h1;
    tick(1);
    cfg_we = 1'h0;
  endtask : set_cfg
  task automatic until_tp(input logic v);
    while (tp !== v && n < 1000) begin
      tick(1);
      n++;
    end
  endtask : until_tp
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    do_reset(1'h1);
    `CHK(txd, 1'h1)
    `CHK(ant, 1'h1)
    n = 0;
    until_tp(1'h0);
    n = 0;
    until_tp(1'h1);
    n = 0;
    until_tp(1'h0);
    `CHK(n, TP_W)
    until_tp(1'h1);
    `CHK(n, TP_P)
    // indicator level against the byte count for both polarities
    for (int p = 0; p < 2; p++) begin
      thr = 9'($random(seed) & 32'hf);
      set_cfg(1'h1, p[0], 1'h1, thr);
      for (int c = 0; c < 18; c++) begin
        out_count = 9'(c);
        tick(3);
        hit = (9'(c) >= thr) && (c != 0);
        `CHK(txd, p[0] ? hit : !hit)
      end
    end
    out_count = '0;
    set_cfg(1'h1, 1'h1, 1'h1, 9'h001);
    repeat (3) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      i_hps_host_model.uart_send(b, 80);
    end
    tick(40);
    `CHK(exp_q.size(), 0)
    i_hps_host_model.i2c_start();
    i_hps_host_model.i2c_xfer({I2C_ADDR_RST, 1'h0}, r, ack);
    `CHK(ack, 1'h0)
    b = 8'($random(seed));
    exp_q.push_back(b);
    i_hps_host_model.i2c_xfer(b, r, ack);
    `CHK(ack, 1'h0)
    i_hps_host_model.i2c_stop();
    i_hps_host_model.i2c_start();
    i_hps_host_model.i2c_xfer({I2C_ADDR_RST ^ 7'h01, 1'h0}, r, ack);
    `CHK(ack, 1'h1)
    i_hps_host_model.i2c_stop();
    tick(1);
    out_data = 8'($random(seed));
    out_valid = 1'h1;
    i_hps_host_model.i2c_start();
    i_hps_host_model.i2c_xfer({I2C_ADDR_RST, 1'h1}, r, ack);
    i_hps_host_model.i2c_xfer(8'hff, r, ack);
    `CHK(r, out_data)
    `CHK(out_valid, 1'h0)
    i_hps_host_model.i2c_stop();
    tick(1);
    // serial transmitter drains the buffer when the indicator is not mapped
    set_cfg(1'h0, 1'h1, 1'h0, 9'h001);
    tick(2);
    out_data = 8'($random(seed));
    out_valid = 1'h1;
    i_hps_host_model.uart_recv(r, 80);
    `CHK(r, out_data)
    `CHK(out_valid, 1'h0)
    // wake input in and out of power save
    power_save = 1'h1;
    tick(4);
    `CHK(ant, 1'h0)
    wake_in = 1'h0;
    tick(8);
    wake_in = 1'h1;
    tick(4);
    power_save = 1'h0;
    tick(4);
    wake_in = 1'h0;
    tick(8);
    wake_in = 1'h1;
    tick(4);
    `CHK(wake_n, 1)
    `CHK(aid_n, 1)
    pin_low = 1'h1;
    tick(10);
    `CHK(sys_rst, 1'h1)
    pin_low = 1'h0;
    tick(10);
    `CHK(sys_rst, 1'h0)
    // strap low: same pins now carry a spi slave
    do_reset(1'h0);
    `CHK(txd_oe, 1'h0)
    b = 8'($random(seed));
    exp_q.push_back(b);
    out_data = 8'($random(seed));
    out_valid = 1'h1;
    i_hps_host_model.spi_xfer(b, r);
    tick(10);
    `CHK(r, out_data)
    `CHK(out_valid, 1'h0)
    `CHK(exp_q.size(), 0)
    stop_test();
  end

  // hang guard, far beyond the expected run
  initial begin
    #100_000;
    err_count++;
    stop_test();
  end
endmodule : hps_top_bench
